//--- mbws_pkg.sv
package mbws_pkg;
    localparam int unsigned AW = 10;
    localparam int unsigned WW = 16;
    localparam int unsigned NW = 9;
    localparam logic [9:0] ADDR_CMD = 10'h100;
    localparam logic [9:0] ADDR_FLAGS = 10'h101;
    localparam logic [9:0] ADDR_LEN = 10'h102;
    localparam logic [9:0] ADDR_PTR = 10'h103;
    localparam logic [9:0] ADDR_STS = 10'h104;
    localparam logic [9:0] ADDR_CLR = 10'h105;
    localparam logic [9:0] ADDR_IEN = 10'h106;
    localparam logic [9:0] ADDR_RES = 10'h107;
    localparam logic [8:0] LEN_MAX = 9'h100;
    localparam logic [8:0] LEN_RST = 9'h001;
    localparam logic [3:0] BIT_SH = 4'h0;
    // flag register bits
    localparam int unsigned F_BORROW = 0;
    localparam int unsigned F_DIR = 1;
    localparam int unsigned F_INC = 2;
    localparam int unsigned F_CLR = 3;
    // command bits
    localparam int unsigned C_WRITE = 0;
    localparam int unsigned C_SHIFT = 1;
    // status / interrupt bits
    localparam int unsigned S_DONE = 0;
    localparam int unsigned S_END = 1;
    localparam int unsigned S_ERR = 2;
    localparam int unsigned NS = 3;
    // result register bits
    localparam int unsigned R_CARRY = 0;
    localparam int unsigned R_END = 1;
    localparam int unsigned R_ERR = 2;
    localparam int unsigned R_BUSY = 3;
    typedef enum logic {MBWS_IDLE, MBWS_SHIFT} mbws_state_t;
endpackage

//--- mbws_core.sv
`timescale 1ns/1ps
module mbws_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [mbws_pkg::AW-1:0] addr,
    input wire logic [mbws_pkg::WW-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [mbws_pkg::WW-1:0] rdata,
    output logic irq,
    output logic busy
);
    function automatic logic is_mem(input logic [mbws_pkg::AW-1:0] a);
        return a[9:8] == 2'h0;
    endfunction

    logic [15:0] mem_q [256];
    mbws_pkg::mbws_state_t st_q, st_d;
    logic [3:0] flags_q, flags_d;
    logic [8:0] len_q, len_d;
    logic [15:0] ptr_q, ptr_d;
    logic [mbws_pkg::NS-1:0] sts_q, sts_d, ien_q, ien_d, ev;
    logic end_q, end_d, err_q, err_d, carry_q, carry_d, cin_q, cin_d;
    logic [7:0] idx_q, idx_d;
    logic [8:0] cnt_q, cnt_d;
    logic [15:0] rdata_q, rdata_d;
    logic irq_q, irq_d, busy_q, busy_d;
    logic mem_we;
    logic [7:0] mem_wa;
    logic [15:0] mem_wd, sh_word;
    logic go_wr, go_sh, len_ok, in_rng, bw, sh_out;
    logic [15:0] p_eff, last;
    logic [7:0] bw_idx;
    logic [3:0] bw_bit;

    assign go_wr = ce && st_q == mbws_pkg::MBWS_IDLE && wr && addr == mbws_pkg::ADDR_CMD
        && wdata[mbws_pkg::C_WRITE];
    assign go_sh = ce && st_q == mbws_pkg::MBWS_IDLE && wr && addr == mbws_pkg::ADDR_CMD
        && !wdata[mbws_pkg::C_WRITE] && wdata[mbws_pkg::C_SHIFT];
    assign len_ok = len_q != 9'h000 && len_q <= mbws_pkg::LEN_MAX;
    assign p_eff = flags_q[mbws_pkg::F_CLR] ? 16'h0000 : ptr_q;
    assign last = {3'h0, len_q, mbws_pkg::BIT_SH} - 16'h0001;
    assign in_rng = len_ok && p_eff <= last;
    // once the end is reached only a pointer clear restarts writing
    assign bw = go_wr && in_rng && (!end_q || flags_q[mbws_pkg::F_CLR]);
    assign bw_idx = p_eff[11:4];
    assign bw_bit = p_eff[3:0];
    assign sh_word = mem_q[idx_q];
    assign sh_out = flags_q[mbws_pkg::F_DIR] ? sh_word[0] : sh_word[15];

    always_comb begin
        st_d = st_q;
        flags_d = flags_q;
        len_d = len_q;
        ptr_d = ptr_q;
        ien_d = ien_q;
        end_d = end_q;
        err_d = err_q;
        carry_d = carry_q;
        cin_d = cin_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        ev = '0;
        mem_we = 1'b0;
        mem_wa = idx_q;
        mem_wd = sh_word;
        if (ce && wr && addr == mbws_pkg::ADDR_IEN) begin
            ien_d = wdata[mbws_pkg::NS-1:0];
        end
        // operands and flags are frozen while a shift runs
        if (ce && wr && st_q == mbws_pkg::MBWS_IDLE) begin
            if (is_mem(addr)) begin
                mem_we = 1'b1;
                mem_wa = addr[7:0];
                mem_wd = wdata;
            end
            if (addr == mbws_pkg::ADDR_FLAGS) begin
                flags_d = wdata[3:0];
            end
            if (addr == mbws_pkg::ADDR_LEN) begin
                len_d = wdata[8:0];
            end
            if (addr == mbws_pkg::ADDR_PTR) begin
                ptr_d = wdata;
            end
        end
        if (go_wr) begin
            ev[mbws_pkg::S_DONE] = 1'b1;
            if (flags_q[mbws_pkg::F_CLR]) begin
                ptr_d = 16'h0000;
                end_d = 1'b0;
            end
            if (!in_rng) begin
                err_d = 1'b1;
                ev[mbws_pkg::S_ERR] = 1'b1;
            end else begin
                err_d = 1'b0;
            end
            if (bw) begin
                mem_we = 1'b1;
                mem_wa = bw_idx;
                mem_wd = mem_q[bw_idx];
                mem_wd[bw_bit] = flags_q[mbws_pkg::F_BORROW];
                if (p_eff == last) begin
                    end_d = 1'b1;
                    ptr_d = p_eff;
                    ev[mbws_pkg::S_END] = 1'b1;
                end else if (flags_q[mbws_pkg::F_INC]) begin
                    ptr_d = p_eff + 16'h0001;
                end
            end
        end
        if (go_sh) begin
            if (!len_ok) begin
                err_d = 1'b1;
                ev[mbws_pkg::S_ERR] = 1'b1;
                ev[mbws_pkg::S_DONE] = 1'b1;
            end else begin
                err_d = 1'b0;
                st_d = mbws_pkg::MBWS_SHIFT;
                cnt_d = len_q;
                cin_d = flags_q[mbws_pkg::F_BORROW];
                idx_d = flags_q[mbws_pkg::F_DIR] ? 8'(len_q - 9'h001) : 8'h00;
            end
        end
        case (st_q)
            mbws_pkg::MBWS_SHIFT: begin
                // one word per cycle; the carry chain rides in cin
                if (ce) begin
                    mem_we = 1'b1;
                    mem_wa = idx_q;
                    if (flags_q[mbws_pkg::F_DIR]) begin
                        mem_wd = {cin_q, sh_word[15:1]};
                        idx_d = idx_q - 8'h01;
                    end else begin
                        mem_wd = {sh_word[14:0], cin_q};
                        idx_d = idx_q + 8'h01;
                    end
                    cin_d = sh_out;
                    cnt_d = cnt_q - 9'h001;
                    if (cnt_q == 9'h001) begin
                        carry_d = sh_out;
                        st_d = mbws_pkg::MBWS_IDLE;
                        ev[mbws_pkg::S_DONE] = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
    end

    always_comb begin
        sts_d = sts_q;
        if (ce && wr && addr == mbws_pkg::ADDR_CLR) begin
            sts_d = sts_d & ~wdata[mbws_pkg::NS-1:0];
        end
        // a new event wins over a clear in the same cycle
        sts_d = sts_d | ev;
        irq_d = |(sts_d & ien_d);
        busy_d = st_d != mbws_pkg::MBWS_IDLE;
        rdata_d = 16'h0000;
        if (ce && rd) begin
            if (is_mem(addr)) begin
                rdata_d = mem_q[addr[7:0]];
            end else begin
                case (addr)
                    mbws_pkg::ADDR_FLAGS: rdata_d = {12'h000, flags_q};
                    mbws_pkg::ADDR_LEN: rdata_d = {7'h00, len_q};
                    mbws_pkg::ADDR_PTR: rdata_d = ptr_q;
                    mbws_pkg::ADDR_STS: rdata_d = {13'h0000, sts_q};
                    mbws_pkg::ADDR_IEN: rdata_d = {13'h0000, ien_q};
                    mbws_pkg::ADDR_RES: rdata_d = {12'h000, busy_q, err_q, end_q, carry_q};
                    default: rdata_d = 16'h0000;
                endcase
            end
        end else if (!ce) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && mem_we) begin
            mem_q[mem_wa] <= mem_wd;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= mbws_pkg::MBWS_IDLE;
            flags_q <= 4'h0;
            len_q <= mbws_pkg::LEN_RST;
            ptr_q <= 16'h0000;
            sts_q <= '0;
            ien_q <= '0;
            end_q <= 1'b0;
            err_q <= 1'b0;
            carry_q <= 1'b0;
            cin_q <= 1'b0;
            idx_q <= 8'h00;
            cnt_q <= 9'h000;
            rdata_q <= 16'h0000;
            irq_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            flags_q <= flags_d;
            len_q <= len_d;
            ptr_q <= ptr_d;
            sts_q <= sts_d;
            ien_q <= ien_d;
            end_q <= end_d;
            err_q <= err_d;
            carry_q <= carry_d;
            cin_q <= cin_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            busy_q <= busy_d;
        end
    end

    assign rdata = rdata_q;
    assign irq = irq_q;
    assign busy = busy_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_ptr_clear;
        go_wr && flags_q[mbws_pkg::F_CLR] && len_ok |=> ptr_q <= 16'h0001;
    endproperty
    a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared");

    property p_bit_copy;
        bw |=> mem_q[$past(bw_idx)][$past(bw_bit)] == $past(flags_q[mbws_pkg::F_BORROW]);
    endproperty
    a_bit_copy: assert property (p_bit_copy) else $error("borrow not written");

    property p_ptr_inc;
        bw && flags_q[mbws_pkg::F_INC] && p_eff != last |=> ptr_q == $past(p_eff) + 16'h0001;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

    property p_end;
        bw && p_eff == last |=> end_q && ptr_q == $past(p_eff) && sts_q[mbws_pkg::S_END];
    endproperty
    a_end: assert property (p_end) else $error("end of matrix not flagged");

    property p_len_range;
        go_wr && len_q > mbws_pkg::LEN_MAX |=> err_q;
    endproperty
    a_len_range: assert property (p_len_range) else $error("bad length accepted");

    property p_ptr_err;
        go_wr && !in_rng |=> err_q && sts_q[mbws_pkg::S_ERR] && ptr_q == $past(p_eff);
    endproperty
    a_ptr_err: assert property (p_ptr_err) else $error("pointer error missed");

    property p_dir;
        go_sh && len_ok |=> st_q == mbws_pkg::MBWS_SHIFT
            && idx_q == (flags_q[mbws_pkg::F_DIR] ? 8'(len_q - 9'h001) : 8'h00);
    endproperty
    a_dir: assert property (p_dir) else $error("shift start word wrong");

    property p_fill;
        st_q == mbws_pkg::MBWS_SHIFT && ce && cnt_q == len_q && !flags_q[mbws_pkg::F_DIR]
            |=> mem_q[$past(idx_q)][0] == $past(flags_q[mbws_pkg::F_BORROW]);
    endproperty
    a_fill: assert property (p_fill) else $error("vacated bit not from borrow");

    property p_fill_right;
        st_q == mbws_pkg::MBWS_SHIFT && ce && cnt_q == len_q && flags_q[mbws_pkg::F_DIR]
            |=> mem_q[$past(idx_q)][15] == $past(flags_q[mbws_pkg::F_BORROW]);
    endproperty
    a_fill_right: assert property (p_fill_right) else $error("vacated top bit not from borrow");

    property p_carry;
        st_q == mbws_pkg::MBWS_SHIFT && ce && cnt_q == 9'h001
            |=> carry_q == $past(sh_out) && st_q == mbws_pkg::MBWS_IDLE;
    endproperty
    a_carry: assert property (p_carry) else $error("carry not taken");

    property p_busy;
        st_q == mbws_pkg::MBWS_SHIFT && cnt_q > 9'h001 |=> st_q == mbws_pkg::MBWS_SHIFT && busy_q;
    endproperty
    a_busy: assert property (p_busy) else $error("shift cut short");
endmodule

//--- mbws_host.sv
`timescale 1ns/1ps
module mbws_host (
    input wire logic clk,
    input wire logic [mbws_pkg::WW-1:0] rdata,
    output logic [mbws_pkg::AW-1:0] addr,
    output logic [mbws_pkg::WW-1:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    // operands are whole words in the matrix memory, never grouped bit operands
    // so every length 1..256 is usable here
    // one command write per operation: the pulsed form, never a held request
    task automatic put(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // released lines flip so nothing leans on a stale value
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic get(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic rst;
    logic ce;
    logic [mbws_pkg::AW-1:0] addr;
    logic [mbws_pkg::WW-1:0] wdata;
    logic wr;
    logic rd;
    logic [mbws_pkg::WW-1:0] rdata;
    logic irq;
    logic busy;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    mbws_core mbws_core_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .busy(busy));
    mbws_host mbws_host_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // about 170 cycles are needed; the ceiling leaves wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic w(input logic [9:0] a, input logic [15:0] d);
        mbws_host_i.put(a, d);
    endtask
    task automatic r(input logic [9:0] a, input logic [15:0] exp, input string what);
        logic [15:0] v;
        mbws_host_i.get(a, v);
        check(what, exp, v);
    endtask
    task automatic pin(input string what, input logic exp, input logic got);
        check(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            #1;
            if (busy === 1'b0) break;
        end
        pin("busy end", 1'b0, busy);
    endtask

    task automatic t_reset();
        r(mbws_pkg::ADDR_LEN, 16'h0001, "len rst");
        r(mbws_pkg::ADDR_STS, 16'h0000, "sts rst");
        r(mbws_pkg::ADDR_RES, 16'h0000, "res rst");
        w(mbws_pkg::ADDR_PTR, 16'hffff);
        r(mbws_pkg::ADDR_PTR, 16'hffff, "ptr width");
        w(10'h1ff, 16'hffff);
        r(10'h1ff, 16'h0000, "unmapped");
    endtask

    task automatic t_error();
        w(10'h001, 16'h0000);
        w(mbws_pkg::ADDR_PTR, 16'h0010);
        w(mbws_pkg::ADDR_FLAGS, 16'h0001);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(mbws_pkg::ADDR_RES, 16'h0004, "err res");
        r(mbws_pkg::ADDR_STS, 16'h0005, "err sts");
        r(10'h001, 16'h0000, "no write");
        w(mbws_pkg::ADDR_LEN, 16'h0101);
        w(mbws_pkg::ADDR_PTR, 16'h0000);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(mbws_pkg::ADDR_RES, 16'h0004, "len 257");
        w(mbws_pkg::ADDR_LEN, 16'h0100);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(mbws_pkg::ADDR_RES, 16'h0000, "len 256");
    endtask

    task automatic t_write();
        w(mbws_pkg::ADDR_LEN, 16'h0001);
        w(10'h000, 16'h0000);
        w(mbws_pkg::ADDR_PTR, 16'h0005);
        w(mbws_pkg::ADDR_FLAGS, 16'h0005);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(10'h000, 16'h0020, "wr bit5");
        r(mbws_pkg::ADDR_PTR, 16'h0006, "ptr inc");
        w(mbws_pkg::ADDR_PTR, 16'h0009);
        w(mbws_pkg::ADDR_FLAGS, 16'h0009);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(10'h000, 16'h0021, "wr bit0");
        r(mbws_pkg::ADDR_PTR, 16'h0000, "ptr clr");
        // back to back commands, borrow low clears bits
        w(10'h000, 16'hffff);
        w(mbws_pkg::ADDR_FLAGS, 16'h0004);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(10'h000, 16'hfffc, "b2b wr");
        r(mbws_pkg::ADDR_PTR, 16'h0002, "b2b ptr");
        // both command bits: the bit write wins, no shift starts
        w(mbws_pkg::ADDR_CMD, 16'h0003);
        #1;
        pin("both busy", 1'b0, busy);
        r(10'h000, 16'hfff8, "both wr");
    endtask

    task automatic t_shift();
        w(mbws_pkg::ADDR_LEN, 16'h0002);
        w(10'h000, 16'h8001);
        w(10'h001, 16'hc000);
        w(mbws_pkg::ADDR_FLAGS, 16'h0000);
        w(mbws_pkg::ADDR_PTR, 16'h0000);
        w(mbws_pkg::ADDR_CMD, 16'h0002);
        #1;
        pin("busy", 1'b1, busy);
        w(mbws_pkg::ADDR_PTR, 16'h0007);
        wait_idle();
        r(10'h000, 16'h0002, "shl w0");
        r(10'h001, 16'h8001, "shl w1");
        r(mbws_pkg::ADDR_RES, 16'h0001, "shl carry");
        r(mbws_pkg::ADDR_PTR, 16'h0000, "busy ptr");
        w(mbws_pkg::ADDR_FLAGS, 16'h0003);
        w(mbws_pkg::ADDR_CMD, 16'h0002);
        wait_idle();
        r(10'h000, 16'h8001, "shr w0");
        r(10'h001, 16'hc000, "shr w1");
        r(mbws_pkg::ADDR_RES, 16'h0000, "shr carry");
        w(mbws_pkg::ADDR_LEN, 16'h0000);
        w(mbws_pkg::ADDR_CMD, 16'h0002);
        #1;
        pin("bad len busy", 1'b0, busy);
        r(mbws_pkg::ADDR_RES, 16'h0004, "bad len shift");
        r(10'h000, 16'h8001, "bad len kept");
    endtask

    task automatic t_end_irq();
        w(mbws_pkg::ADDR_CLR, 16'h0007);
        w(mbws_pkg::ADDR_IEN, 16'h0001);
        #1;
        pin("irq idle", 1'b0, irq);
        w(mbws_pkg::ADDR_LEN, 16'h0001);
        w(10'h000, 16'h0000);
        w(mbws_pkg::ADDR_PTR, 16'h000f);
        w(mbws_pkg::ADDR_FLAGS, 16'h0005);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        #1;
        pin("irq done", 1'b1, irq);
        r(10'h000, 16'h8000, "last bit");
        r(mbws_pkg::ADDR_PTR, 16'h000f, "last ptr");
        r(mbws_pkg::ADDR_RES, 16'h0002, "end res");
        w(mbws_pkg::ADDR_FLAGS, 16'h0004);
        w(mbws_pkg::ADDR_CMD, 16'h0001);
        r(10'h000, 16'h8000, "stopped");
        w(mbws_pkg::ADDR_CLR, 16'h0001);
        #1;
        pin("irq masked", 1'b0, irq);
        w(mbws_pkg::ADDR_IEN, 16'h0002);
        #1;
        pin("irq end", 1'b1, irq);
        @(posedge clk);
        ce <= 1'b0;
        w(mbws_pkg::ADDR_PTR, 16'h0003);
        ce <= 1'b1;
        r(mbws_pkg::ADDR_PTR, 16'h000f, "ce frozen");
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        pin("irq rst", 1'b0, irq);
        t_reset();
        t_error();
        t_write();
        t_shift();
        t_end_irq();
        tally_and_finish();
    end
endmodule
